// *** slb_strap_latch.v ***
// Operation
// - Configuration options come from dedicated pins, captured at start-up.
// - Captured options held in status word and pull-control word.
// - Six pull-enable straps shared with general pins 0 to 5.
// - Pull-enable strap disables that interface's output drivers.
// - Host, cell, eth1 get pull-up and pull-down; tdm ports pull-down only.
// - Shared pins re-sampled on every later external reset.
// - Reset-status output active while any reset is in progress.
// - Cold or warm reset release latches boot mode, which picks next step.
// - Immediate, host and ROM boot; ROM loaders serve other interfaces.
// - Host boot holds cores in reset until host releases them.
// - Immediate boot starts cores at level-2 base right at release.
// - Two-wire boot loads code or tables, then runs code or resumes ROM.
// - Link, cell, ethernet boots wait for final section, then execute.
// - Two-wire interface may supply user code or tables for other modes.
// - Core clock synthesiser disabled and bypassed after reset release.
// - Cold and warm resets both re-sample all straps.
// - Internal soft resets do not re-latch straps but show on status.
`timescale 1ns/100ps
`include "slb_consts.vh"
module slb_strap_latch (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // External reset pins, active low
    input wire cold_rst_n,
    input wire warm_rst_n,
    // Internal soft/system reset request
    input wire soft_rst,
    // Strap pins
    input wire byte_order_strap,
    input wire [3:0] boot_select_strap,
    input wire memory_ctrl_enable_strap,
    input wire clock_output_enable_strap,
    input wire [2:0] eth0_interface_select,
    input wire [1:0] eth1_interface_select,
    input wire serial_link_enable_strap,
    input wire [4:0] general_option_straps,
    // Shared general pins 0..5 carrying the pull-enable straps
    input wire [5:0] gpio_strap,
    // Boot progress from loaders and host
    input wire host_release,
    input wire twi_last_code,
    input wire twi_params_done,
    input wire load_last_section,
    // Latched words
    output reg [17:0] strap_status_register,
    output reg [5:0] strap_control_register,
    // Reset status
    output reg reset_in_progress_out,
    // Core control
    output reg core_reset_n,
    output reg core_start_l2,
    output reg rom_exec,
    output reg loader_active,
    // Clock synthesiser enable, off after release
    output reg synth_enable,
    // Per-interface output-driver enable
    output reg [5:0] if_drive_en,
    // Pull-up and pull-down enables per interface
    output reg [5:0] if_pullup_en,
    output reg [5:0] if_pulldown_en
);
    // Boot sequencer states
    localparam [2:0] S_RESET = 3'h0;
    localparam [2:0] S_HOLD = 3'h1;
    localparam [2:0] S_LOAD = 3'h2;
    localparam [2:0] S_RUN = 3'h3;
    localparam [2:0] S_ROM = 3'h4;
    // Tdm ports have no pull-up resistor, only pull-down
    localparam [5:0] PU_MASK = (6'h01 << `SLB_CTL_HOST) | (6'h01 << `SLB_CTL_CELL) |
        (6'h01 << `SLB_CTL_ETH1);
    wire [2:0] rst_s;
    wire [17:0] st_s;
    wire [5:0] ctl_s;
    wire [3:0] prog_s;
    reg ext_prev_r;
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    wire ext_active;
    wire release_edge;
    wire [3:0] mode;
    wire soft_active;
    wire boot_go;

    // Pins come from outside the clock domain
    slb_sync #(.W(3)) u_rst_sync (
        .clk(clk),
        .resetn(resetn),
        .d({cold_rst_n, warm_rst_n, soft_rst}),
        .q(rst_s)
    );
    slb_sync #(.W(18)) u_st_sync (
        .clk(clk),
        .resetn(resetn),
        .d({general_option_straps, serial_link_enable_strap, eth1_interface_select,
            eth0_interface_select, clock_output_enable_strap, memory_ctrl_enable_strap,
            boot_select_strap, byte_order_strap}),
        .q(st_s)
    );
    slb_sync #(.W(6)) u_ctl_sync (
        .clk(clk),
        .resetn(resetn),
        .d(gpio_strap),
        .q(ctl_s)
    );
    slb_sync #(.W(4)) u_prog_sync (
        .clk(clk),
        .resetn(resetn),
        .d({host_release, twi_last_code, twi_params_done, load_last_section}),
        .q(prog_s)
    );

    // Either external pin low counts; soft reset excluded on purpose
    assign ext_active = !rst_s[2] || !rst_s[1];
    assign soft_active = rst_s[0];
    assign release_edge = ext_prev_r && !ext_active;
    // Hold the sequencer one edge past capture so it never reads the stale mode
    assign boot_go = !ext_active && !soft_active && !release_edge;
    assign mode = strap_status_register[`SLB_ST_BOOT_HI:`SLB_ST_BOOT_LO];

    // Capture straps only on external release, so soft resets keep them
    always @(posedge clk) begin
        if (!resetn) begin
            ext_prev_r <= 1'b1;
            strap_status_register <= `SLB_ST_RST;
            strap_control_register <= `SLB_CTL_RST;
        end else begin
            ext_prev_r <= ext_active;
            if (release_edge) begin
                strap_status_register <= st_s;
                strap_control_register <= ctl_s;
            end
        end
    end

    // Reset status covers external and soft resets alike
    always @(posedge clk) begin
        if (!resetn) begin
            reset_in_progress_out <= 1'b1;
        end else begin
            reset_in_progress_out <= ext_active || soft_active;
        end
    end

    // Pull enable turns drivers off; tdm ports get pull-down only
    always @(posedge clk) begin
        if (!resetn) begin
            if_drive_en <= 6'h00;
            if_pullup_en <= 6'h00;
            if_pulldown_en <= 6'h00;
        end else begin
            if_drive_en <= ~strap_control_register & {6{!reset_in_progress_out}};
            if_pulldown_en <= strap_control_register;
            if_pullup_en <= strap_control_register & PU_MASK;
        end
    end

    // Boot sequencer next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_RESET: begin
                if (boot_go) begin
                    case (mode)
                        `SLB_BOOT_IMM: state_nxt = S_RUN;
                        `SLB_BOOT_HOST: state_nxt = S_HOLD;
                        default: state_nxt = S_LOAD;
                    endcase
                end
            end
            S_HOLD: begin
                if (prog_s[3]) begin
                    state_nxt = S_RUN;
                end
            end
            S_LOAD: begin
                if (mode == `SLB_BOOT_TWI) begin
                    if (prog_s[2]) begin
                        state_nxt = S_RUN;
                    end else if (prog_s[1]) begin
                        state_nxt = S_ROM;
                    end
                end else if (prog_s[0]) begin
                    state_nxt = S_RUN;
                end
            end
            S_RUN: state_nxt = S_RUN;
            S_ROM: state_nxt = S_ROM;
            default: state_nxt = S_RESET;
        endcase
        if (ext_active || soft_active) begin
            state_nxt = S_RESET;
        end
    end

    // Sequencer register and core controls
    always @(posedge clk) begin
        if (!resetn) begin
            state_r <= S_RESET;
            core_reset_n <= 1'b0;
            core_start_l2 <= 1'b0;
            rom_exec <= 1'b0;
            loader_active <= 1'b0;
            synth_enable <= 1'b0;
        end else begin
            state_r <= state_nxt;
            core_reset_n <= (state_nxt == S_RUN) || (state_nxt == S_ROM) ||
                (state_nxt == S_LOAD);
            core_start_l2 <= (state_nxt == S_RUN);
            rom_exec <= (state_nxt == S_LOAD) || (state_nxt == S_ROM);
            loader_active <= (state_nxt == S_LOAD);
            // Synthesiser stays bypassed; software enables it elsewhere
            synth_enable <= 1'b0;
        end
    end
endmodule // slb_strap_latch

// *** slb_consts.vh ***
`ifndef SLB_CONSTS_VH
`define SLB_CONSTS_VH
// Status word layout
`define SLB_ST_ORDER 0
`define SLB_ST_BOOT_LO 1
`define SLB_ST_BOOT_HI 4
`define SLB_ST_MEM 5
`define SLB_ST_CLKO 6
`define SLB_ST_E0_LO 7
`define SLB_ST_E0_HI 9
`define SLB_ST_E1_LO 10
`define SLB_ST_E1_HI 11
`define SLB_ST_LINK 12
`define SLB_ST_GP_LO 13
`define SLB_ST_GP_HI 17
`define SLB_ST_W 18
`define SLB_CTL_W 6
// Control word bit positions
`define SLB_CTL_HOST 0
`define SLB_CTL_CELL 1
`define SLB_CTL_TDM0 2
`define SLB_CTL_TDM2 4
`define SLB_CTL_ETH1 5
// Reset values (pull-up/pull-down defaults)
`define SLB_ST_RST 18'h00003
`define SLB_CTL_RST 6'h00
// Boot mode codes
`define SLB_BOOT_IMM 4'h0
`define SLB_BOOT_HOST 4'h1
`define SLB_BOOT_TWI 4'h2
`define SLB_BOOT_LINK 4'h3
`define SLB_BOOT_CELL 4'h4
`define SLB_BOOT_ETH 4'h5
`endif

// *** slb_sync.v ***
`timescale 1ns/100ps
// Two-stage synchroniser, one per bus bit
module slb_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    // First stage is read only by the second
    always @(posedge clk) begin
        if (!resetn) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // slb_sync

// *** slb_chk_asserts.sv ***
`timescale 1ns/100ps
module slb_chk (
    // Clock, reset and host pins
    input wire clk, resetn, cold_rst_n, warm_rst_n, soft_rst, host_release,
    // Strap pins
    input wire byte_order_strap, memory_ctrl_enable_strap, clock_output_enable_strap,
    input wire serial_link_enable_strap,
    input wire [3:0] boot_select_strap,
    input wire [2:0] eth0_interface_select,
    input wire [1:0] eth1_interface_select,
    input wire [4:0] general_option_straps,
    input wire [5:0] gpio_strap, strap_control_register, if_drive_en, if_pullup_en, if_pulldown_en,
    // Status and core control
    input wire [17:0] strap_status_register,
    input wire reset_in_progress_out, core_reset_n, core_start_l2, synth_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Both external reset pins released
    sequence ext_rel_s;
        $rose(cold_rst_n && warm_rst_n);
    endsequence
    // Host boot latched, host has not let go
    sequence host_wait_s;
        (strap_status_register[4:1] == 4'h1 && !host_release) [*4];
    endsequence
    // Compare with the levels seen at release; shared pins may act as GPIO later
    status_capture_a: assert property (ext_rel_s |-> ##4
        strap_status_register == $past({general_option_straps, serial_link_enable_strap,
        eth1_interface_select, eth0_interface_select, clock_output_enable_strap,
        memory_ctrl_enable_strap, boot_select_strap, byte_order_strap}, 4))
        else $error("status word not captured");
    ctrl_capture_a: assert property (ext_rel_s |-> ##4
        strap_control_register == $past(gpio_strap, 4)) else $error("control word not captured");
    latch_hold_a: assert property ((cold_rst_n && warm_rst_n) [*8] |=>
        $stable(strap_status_register) && $stable(strap_control_register))
        else $error("latched straps moved");
    drive_gate_a: assert property ((if_drive_en & strap_control_register) == 6'h00)
        else $error("driver on with pulls on");
    pull_map_a: assert property ($stable(strap_control_register) [*2] |->
        if_pullup_en == (strap_control_register & 6'h23) && if_pulldown_en == strap_control_register)
        else $error("pull enables wrong");
    rst_status_a: assert property ((!cold_rst_n || !warm_rst_n || soft_rst) [*4] |->
        reset_in_progress_out) else $error("reset status low in reset");
    host_hold_a: assert property (host_wait_s |-> !core_reset_n)
        else $error("cores run before host release");
    imm_start_a: assert property ((strap_status_register[4:1] == 4'h0 &&
        !reset_in_progress_out) [*4] |-> core_reset_n && core_start_l2)
        else $error("immediate boot not started");
    synth_off_a: assert property (!synth_enable)
        else $error("synthesiser enabled");
endmodule // slb_chk
bind slb_strap_latch slb_chk chk_u (.*);

// *** slb_board.sv ***
`timescale 1ns/100ps
module slb_board (
    // Intent from the bench
    input wire [5:0] pull_want,
    input wire gpio_use,
    input wire host_go,
    // Device side
    input wire reset_in_progress_out,
    output wire [5:0] gpio_strap,
    output wire host_release
);
    // Strap level forced while reset shows or GPIO use is off; otherwise pins act as GPIO and show the inverse
    assign gpio_strap = (reset_in_progress_out || !gpio_use) ? pull_want : ~pull_want;
    // Host frees the cores once loaded; synthesiser setup and ready handshakes are abstracted
    assign host_release = host_go;
endmodule // slb_board

// *** test_strap_latch_boot_select.sv ***
`timescale 1ns/100ps
`include "slb_consts.vh"
module test_strap_latch_boot_select;
    logic clk, resetn, cold_rst_n, warm_rst_n, soft_rst, host_release, host_go, gpio_use;
    logic byte_order_strap, memory_ctrl_enable_strap, clock_output_enable_strap;
    logic serial_link_enable_strap, twi_last_code, twi_params_done, load_last_section;
    logic [3:0] boot_select_strap;
    logic [2:0] eth0_interface_select;
    logic [1:0] eth1_interface_select;
    logic [4:0] general_option_straps;
    logic [5:0] gpio_strap, pull_want, strap_control_register, if_drive_en, if_pullup_en;
    logic [5:0] if_pulldown_en;
    logic [17:0] strap_status_register;
    logic reset_in_progress_out, core_reset_n, core_start_l2, rom_exec, loader_active, synth_enable;
    int bad_count = 0;
    int tests_run = 0;
    slb_strap_latch dut_u (.*);
    slb_board brd_u (.*);
    // 20 MHz clock
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Inputs move 5 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic set_straps(input logic [3:0] boot, input logic [5:0] pulls);
        // Option bit 4 high keeps ethernet boot safe on a slow reference
        {general_option_straps, serial_link_enable_strap, eth1_interface_select} = 8'had;
        {eth0_interface_select, clock_output_enable_strap, memory_ctrl_enable_strap} = 5'h15;
        boot_select_strap = boot;
        byte_order_strap = 1'h0;
        pull_want = pulls;
    endtask
    function automatic logic [17:0] exp_st(input logic [3:0] boot);
        return {8'had, 5'h15, boot, 1'h0};
    endfunction
    // Pin low long enough for straps to settle before release
    task automatic ext_reset(input bit use_warm);
        if (use_warm) warm_rst_n = 1'h0;
        else cold_rst_n = 1'h0;
        cyc(6);
        warm_rst_n = 1'h1;
        cold_rst_n = 1'h1;
        cyc(8);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, far beyond the 171 cycles needed
    initial begin
        #100000;
        bad_count++;
        complete_run;
    end
    // Main sequence
    initial begin
        {resetn, cold_rst_n, warm_rst_n, soft_rst, gpio_use, host_go} = 6'h00;
        {twi_last_code, twi_params_done, load_last_section} = 3'h0;
        set_straps(`SLB_BOOT_IMM, 6'h25);
        cyc(3);
        resetn = 1'h1;
        cyc(1);
        chk(strap_status_register, `SLB_ST_RST);
        chk({strap_control_register, reset_in_progress_out}, 7'h01);
        cold_rst_n = 1'h1;
        cyc(8);
        chk(strap_status_register, `SLB_ST_RST);
        warm_rst_n = 1'h1;
        cyc(8);
        chk(strap_status_register, exp_st(`SLB_BOOT_IMM));
        chk({if_drive_en, if_pullup_en, if_pulldown_en}, 18'h1a865);
        chk({core_reset_n, core_start_l2, synth_enable, reset_in_progress_out}, 4'hc);
        $display("test capture done");
        gpio_use = 1'h1;
        set_straps(`SLB_BOOT_HOST, 6'h1a);
        soft_rst = 1'h1;
        cyc(4);
        chk(reset_in_progress_out, 1'h1);
        soft_rst = 1'h0;
        cyc(8);
        chk({strap_status_register, strap_control_register}, {exp_st(`SLB_BOOT_IMM), 6'h25});
        // Pins stay in GPIO use; the board restores straps from the reset status
        ext_reset(1'h1);
        cyc(3);
        chk({strap_status_register, strap_control_register}, {exp_st(`SLB_BOOT_HOST), 6'h1a});
        chk(core_reset_n, 1'h0);
        host_go = 1'h1;
        cyc(6);
        chk(core_reset_n, 1'h1);
        $display("test soft and warm done");
        gpio_use = 1'h0;
        for (int m = 2; m < 7; m++) begin
            set_straps(m[3:0], 6'h3f);
            ext_reset(m[0]);
            chk(loader_active, 1'h1);
        end
        load_last_section = 1'h1;
        cyc(6);
        chk({core_reset_n, loader_active, core_start_l2}, 3'h5);
        load_last_section = 1'h0;
        set_straps(`SLB_BOOT_TWI, 6'h00);
        ext_reset(1'h0);
        twi_params_done = 1'h1;
        cyc(6);
        chk({rom_exec, loader_active, core_start_l2}, 3'h4);
        twi_params_done = 1'h0;
        ext_reset(1'h1);
        chk(loader_active, 1'h1);
        twi_last_code = 1'h1;
        cyc(6);
        chk({rom_exec, loader_active, core_start_l2}, 3'h1);
        $display("test loaders done");
        complete_run;
    end
endmodule // test_strap_latch_boot_select
